// File: core/ospd_path.sv
// one divider, duty and coarse phase path of an output stage
// assumes src_tick is high for one clk_sys cycle per source clock period
`timescale 1ns/1ps
module ospd_path import ospd_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // source
  input wire logic src_tick,
  // configuration
  input wire logic [DIV_W-1:0] div_ratio,
  input wire logic [DIV_W-1:0] high_width,
  // coarse phase request
  input wire logic [ADJ_W-1:0] coarse_phase_step,
  input wire logic step_req,
  // results
  output logic clk_out,
  output logic period_start,
  output logic step_pending
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [LEN_W-1:0] cnt_reg;
  logic [LEN_W-1:0] low_len_reg;
  logic [ADJ_W-1:0] step_reg;
  logic [LEN_W-1:0] high_next;
  logic [LEN_W-1:0] low_next;
  logic [LEN_W-1:0] base_hi;
  logic [LEN_W-1:0] base_lo;
  logic [SUM_W-1:0] adj_hi;
  logic [SUM_W-1:0] adj_lo;
  logic [SUM_W-1:0] sum_hi;
  logic [SUM_W-1:0] sum_lo;
  logic [SUM_W-1:0] adj_ext;
  logic phase_end;

  assign phase_end = clk_en && src_tick && (cnt_reg <= ONE_LEN);
  // period ends after the low half, or after the high half when there is no low half
  assign period_start = phase_end && (!clk_out || (low_len_reg == ZERO_LEN));

  // ---------------------------------------------------------------
  // lengths of the next period
  // ---------------------------------------------------------------
  always_comb begin
    adj_ext = {{(SUM_W-ADJ_W){step_reg[ADJ_W-1]}}, step_reg};
    if (high_width == ZERO_DIV) begin
      // odd ratios put the spare cycle in the high half
      base_hi = {3'h0, div_ratio - (div_ratio >> 1)};
      base_lo = {3'h0, div_ratio >> 1};
      adj_hi = $signed(adj_ext) >>> 1;
    end else begin
      base_hi = {3'h0, high_width};
      // a width at or above the ratio leaves no low half unless a coarse step is pending
      base_lo = (high_width < div_ratio) ? {3'h0, div_ratio - high_width} : ZERO_LEN;
      adj_hi = {SUM_W{1'b0}};
    end
    adj_lo = adj_ext - adj_hi;
    sum_hi = {1'b0, base_hi} + adj_hi;
    sum_lo = {1'b0, base_lo} + adj_lo;
    high_next = base_hi;
    low_next = base_lo;
    if (step_pending) begin
      // shortening stops at the floor; lengthening is never limited here
      high_next = ($signed(sum_hi) < $signed({1'b0, MIN_PHASE})) ? MIN_PHASE : sum_hi[LEN_W-1:0];
      low_next = ($signed(sum_lo) < $signed({1'b0, MIN_PHASE})) ? MIN_PHASE : sum_lo[LEN_W-1:0];
      if (high_width != ZERO_DIV) begin
        high_next = base_hi;
      end
    end
  end

  // ---------------------------------------------------------------
  // period counter and output level
  // ---------------------------------------------------------------
  // ratio, width and step are sampled only at a period boundary, so no runt appears
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= ONE_LEN;
      low_len_reg <= ZERO_LEN;
      clk_out <= 1'b0;
    end else if (clk_en && src_tick) begin
      if (cnt_reg > ONE_LEN) begin
        cnt_reg <= cnt_reg - ONE_LEN;
      end else if (!period_start) begin
        clk_out <= 1'b0;
        cnt_reg <= low_len_reg;
      end else begin
        clk_out <= 1'b1;
        cnt_reg <= high_next;
        low_len_reg <= low_next;
      end
    end
  end

  // ---------------------------------------------------------------
  // coarse step latch
  // ---------------------------------------------------------------
  // a new request in the boundary cycle wins over the clear and waits one more period
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      step_pending <= 1'b0;
      step_reg <= ZERO_ADJ;
    end else if (clk_en) begin
      if (step_req) begin
        step_pending <= 1'b1;
        step_reg <= coarse_phase_step;
      end else if (period_start) begin
        step_pending <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_period_starts_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
    period_start |=> clk_out)
    else $error("period did not start high");
  a_width_loaded: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (period_start && !step_pending && high_width != ZERO_DIV) |=> (cnt_reg == {3'h0, $past(high_width)}))
    else $error("high width not loaded");
  a_even_duty: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (period_start && !step_pending && high_width == ZERO_DIV && div_ratio > 32'h00000001)
    |=> (cnt_reg + low_len_reg == {3'h0, $past(div_ratio)}) && (cnt_reg >= low_len_reg))
    else $error("even duty halves wrong");
  a_floor_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (period_start && step_pending)
    |=> ((cnt_reg >= MIN_PHASE) || ($past(high_width) != ZERO_DIV)) && (low_len_reg >= MIN_PHASE))
    else $error("coarse step went below floor");
  a_step_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (period_start && step_pending && !step_req) |=> !step_pending)
    else $error("coarse step not cleared");
  a_step_latched: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && step_req) |=> (step_pending && step_reg == $past(coarse_phase_step)))
    else $error("coarse step request lost");
  a_high_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (period_start && step_pending && high_width != ZERO_DIV) |=> (cnt_reg == {3'h0, $past(high_width)}))
    else $error("programmed high width altered by step");
  a_phase_flip: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && src_tick && cnt_reg > ONE_LEN) |=> $stable(clk_out))
    else $error("output toggled mid phase");
endmodule

// File: core/ospd_pkg.sv
// constants shared by the output stage, its paths and its pin drivers
// assumes one system clock; each source clock cycle arrives as a one-cycle tick
package ospd_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DIV_W = 32;              // divide ratio and high width
  localparam int ADJ_W = 34;              // signed coarse step, +/- 2^33
  localparam int LEN_W = 35;              // phase length after adjustment
  localparam int SUM_W = 36;              // signed working width
  // ---------------------------------------------------------------
  // fixed figures
  // ---------------------------------------------------------------
  localparam logic [LEN_W-1:0] MIN_PHASE = 35'h000000002;  // floor of each half that a coarse step adjusts
  localparam logic [LEN_W-1:0] ONE_LEN = 35'h000000001;
  localparam logic [LEN_W-1:0] ZERO_LEN = 35'h000000000;
  localparam logic [DIV_W-1:0] ZERO_DIV = 32'h00000000;
  localparam logic [ADJ_W-1:0] ZERO_ADJ = 34'h000000000;
  // ---------------------------------------------------------------
  // stage and source numbering
  // ---------------------------------------------------------------
  localparam int NUM_STAGES = 4;          // stages 4..7
  localparam int NUM_SOURCES = 4;         // fractional dividers 4..7
  localparam int SRC_FD4 = 0;
  localparam int SRC_FD5 = 1;
  localparam int SRC_FD6 = 2;
  localparam int SRC_FD7 = 3;
  localparam int STG_4 = 0;
  localparam int STG_5 = 1;
  localparam int STG_6 = 2;
  localparam int STG_7 = 3;
endpackage

// File: core/ospd_pin.sv
// pin driver of one output buffer: differential or two single-ended copies
// assumes the stage clock arrives already registered in the same domain
`timescale 1ns/1ps
module ospd_pin import ospd_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // configuration
  input wire logic diff_mode,
  input wire logic comp_invert,
  // stage clock
  input wire logic stage_clk,
  // pins
  output logic true_output_pin,
  output logic complement_output_pin
);
  // ---------------------------------------------------------------
  // pin copies
  // ---------------------------------------------------------------
  // both copies come from one flop stage so frequency and phase match
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      true_output_pin <= 1'b0;
      complement_output_pin <= 1'b0;
    end else if (clk_en) begin
      true_output_pin <= stage_clk;
      if (diff_mode) begin
        complement_output_pin <= ~stage_clk;
      end else begin
        complement_output_pin <= comp_invert ? ~stage_clk : stage_clk;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_diff_pair_opposite: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && diff_mode) |=> (complement_output_pin == ~true_output_pin))
    else $error("differential pair not complementary");
  a_se_copy_match: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !diff_mode && !comp_invert) |=> (complement_output_pin == true_output_pin))
    else $error("single-ended copies differ");
endmodule

// File: core/ospd_stage_top.sv
// four output stages (4..7) with source selection, paths and pin drivers
// assumes fractional divider clocks arrive as one-cycle ticks on clk_sys
`timescale 1ns/1ps
module ospd_stage_top import ospd_pkg::*; #(
  parameter int PATHS = 1
) (
  // clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // fractional divider clocks 4..7 as ticks
  input wire logic [NUM_SOURCES-1:0] fractional_divider_clock,
  // stage_source_selectors
  input wire logic stage4_source_select,
  input wire logic stage7_source_select,
  // per path configuration, index stage*PATHS+path
  input wire logic [NUM_STAGES*PATHS-1:0][DIV_W-1:0] div_ratio,
  input wire logic [NUM_STAGES*PATHS-1:0][DIV_W-1:0] high_width,
  input wire logic [NUM_STAGES*PATHS-1:0][ADJ_W-1:0] coarse_phase_step,
  input wire logic [NUM_STAGES*PATHS-1:0] step_req,
  input wire logic [NUM_STAGES*PATHS-1:0] diff_mode,
  input wire logic [NUM_STAGES*PATHS-1:0] comp_invert,
  // pins
  output logic [NUM_STAGES*PATHS-1:0] true_output_pin,
  output logic [NUM_STAGES*PATHS-1:0] complement_output_pin,
  // status
  output logic [NUM_STAGES*PATHS-1:0] step_pending,
  output logic [NUM_STAGES-1:0] source_in_use
);
  // ---------------------------------------------------------------
  // source selection
  // ---------------------------------------------------------------
  logic [NUM_STAGES-1:0] stage_tick;
  logic [NUM_STAGES-1:0] stage_boundary;
  logic [NUM_STAGES*PATHS-1:0] path_clk;
  logic [NUM_STAGES*PATHS-1:0] path_start;
  logic sel4_reg;
  logic sel7_reg;

  // the selector follows its input only at the first path's boundary,
  // so a switch never cuts the first path's running half short
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel4_reg <= 1'b0;
      sel7_reg <= 1'b0;
    end else if (clk_en) begin
      if (stage_boundary[STG_4]) begin
        sel4_reg <= stage4_source_select;
      end
      if (stage_boundary[STG_7]) begin
        sel7_reg <= stage7_source_select;
      end
    end
  end

  // fixed and selectable routing of the divider clocks
  always_comb begin
    stage_tick[STG_4] = sel4_reg ? fractional_divider_clock[SRC_FD5] : fractional_divider_clock[SRC_FD4];
    stage_tick[STG_5] = fractional_divider_clock[SRC_FD5];
    stage_tick[STG_6] = fractional_divider_clock[SRC_FD6];
    stage_tick[STG_7] = sel7_reg ? fractional_divider_clock[SRC_FD7] : fractional_divider_clock[SRC_FD6];
  end

  assign source_in_use = {sel7_reg, 1'b0, 1'b0, sel4_reg};

  // ---------------------------------------------------------------
  // paths and pin drivers
  // ---------------------------------------------------------------
  // every path of a stage shares the stage tick; each has its own step, so
  // coarse phase stays per output
  for (genvar s = 0; s < NUM_STAGES; s++) begin : g_stage
    assign stage_boundary[s] = path_start[s*PATHS];
    for (genvar p = 0; p < PATHS; p++) begin : g_path
      ospd_path u_path (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .src_tick(stage_tick[s]),
        .div_ratio(div_ratio[s*PATHS+p]),
        .high_width(high_width[s*PATHS+p]),
        .coarse_phase_step(coarse_phase_step[s*PATHS+p]),
        .step_req(step_req[s*PATHS+p]),
        .clk_out(path_clk[s*PATHS+p]),
        .period_start(path_start[s*PATHS+p]),
        .step_pending(step_pending[s*PATHS+p])
      );
      ospd_pin u_pin (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .diff_mode(diff_mode[s*PATHS+p]),
        .comp_invert(comp_invert[s*PATHS+p]),
        .stage_clk(path_clk[s*PATHS+p]),
        .true_output_pin(true_output_pin[s*PATHS+p]),
        .complement_output_pin(complement_output_pin[s*PATHS+p])
      );
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_sel4_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !stage_boundary[STG_4] |=> $stable(sel4_reg))
    else $error("stage 4 source changed mid period");
  a_sel7_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !stage_boundary[STG_7] |=> $stable(sel7_reg))
    else $error("stage 7 source changed mid period");
endmodule

// File: testbench/ospd_rx_model.sv
// downstream clock receiver model: measures high and low run lengths of one pin
// assumes the pin is registered on clk_sys and sits low through reset
`timescale 1ns/1ps
module ospd_rx_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // watched pin
  input wire logic pin,
  // last full period, valid while per_done is high
  output logic [31:0] hi_len,
  output logic [31:0] lo_len,
  output logic per_done
);
  // ---------------------------------------------------------------
  // run length counter
  // ---------------------------------------------------------------
  logic prev_reg;
  logic [31:0] cnt_reg;

  // a rise closes a period; lengths are in clk_sys cycles, so a tick rate above one scales them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
      cnt_reg <= 32'h00000001;
      hi_len <= 32'h00000000;
      lo_len <= 32'h00000000;
      per_done <= 1'b0;
    end else begin
      prev_reg <= pin;
      per_done <= pin & ~prev_reg;
      if (pin == prev_reg) begin
        cnt_reg <= cnt_reg + 32'h00000001;
      end else begin
        cnt_reg <= 32'h00000001;
        if (pin) begin
          lo_len <= cnt_reg;  // low run just ended
        end else begin
          hi_len <= cnt_reg;  // high run just ended
        end
      end
    end
  end
endmodule

// File: testbench/ospd_stage_top_tb.sv
// self-checking bench for the four output stages, two paths each
// assumes source ticks at fixed rates: divider 4 and 6 every cycle, 5 every second, 7 every third
`timescale 1ns/1ps
module ospd_stage_top_tb import ospd_pkg::*; ;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int N = NUM_STAGES * 2;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [NUM_SOURCES-1:0] fdc = '0;
  logic sel4 = 1'b0;
  logic sel7 = 1'b0;
  logic [N-1:0][DIV_W-1:0] ratio = '0;
  logic [N-1:0][DIV_W-1:0] width = '0;
  logic [N-1:0][ADJ_W-1:0] step = '0;
  logic [N-1:0] req = '0;
  logic [N-1:0] dm = '0;
  logic [N-1:0] ci = '0;
  logic [N-1:0] tp, cp, pend, done;
  logic [NUM_STAGES-1:0] siu;
  logic [31:0] hl [N];
  logic [31:0] ll [N];
  int rv [N];
  int wv [N];
  int num_errors = 0;
  int num_checks = 0;
  int tcnt = 0;
  bit mon_en = 1'b0;
  logic en = 1'b1;
  logic [N-1:0] frz;

  always #5 clk_sys = ~clk_sys;

  // tick pattern gives the two sources of each selector different rates so a wrong selector shows as a wrong length
  always @(posedge clk_sys) begin
    tcnt <= tcnt + 1;
    fdc <= {(tcnt % 3 == 0), 1'b1, (tcnt % 2 == 0), 1'b1};
  end

  ospd_stage_top #(.PATHS(2)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(en),
    .fractional_divider_clock(fdc), .stage4_source_select(sel4), .stage7_source_select(sel7),
    .div_ratio(ratio), .high_width(width), .coarse_phase_step(step), .step_req(req),
    .diff_mode(dm), .comp_invert(ci), .true_output_pin(tp), .complement_output_pin(cp),
    .step_pending(pend), .source_in_use(siu));

  for (genvar g = 0; g < N; g++) begin : g_rx
    ospd_rx_model i_rx (.clk_sys(clk_sys), .rst_n(rst_n), .pin(tp[g]), .hi_len(hl[g]),
      .lo_len(ll[g]), .per_done(done[g]));
  end

  // ---------------------------------------------------------------
  // compare and model tasks
  // ---------------------------------------------------------------
  task automatic chk_len(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // clk_sys cycles per source cycle of path i
  function automatic int rate(input int i);
    case (i / 2)
      0: return sel4 ? 2 : 1;
      1: return 2;
      2: return 1;
      default: return sel7 ? 3 : 1;
    endcase
  endfunction

  task automatic wait_per(input int i);
    for (int k = 0; k < 3000; k++) begin
      @(posedge clk_sys);
      #1;
      if (done[i] === 1'b1) begin
        break;
      end
    end
    chk_bit(done[i], 1'b1);
  endtask

  // expected halves: odd ratio puts the spare cycle high, step split floors toward the high half
  task automatic check_per(input int i, input int r, input int w, input int s);
    int h;
    int l;
    h = (w == 0) ? r - r / 2 : w;
    l = r - h;
    if (s != 0) begin
      h = (w == 0) ? h + (s >>> 1) : h;
      l = (w == 0) ? l + s - (s >>> 1) : l + s;
      h = (h < 2) ? 2 : h;
      l = (l < 2) ? 2 : l;
    end
    wait_per(i);
    chk_len(hl[i], 32'(h * rate(i)));
    chk_len(ll[i], 32'(l * rate(i)));
  endtask

  task automatic setup(input bit even);
    mon_en = 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < N; i++) begin
      rv[i] = 5 + $urandom % 20;
      wv[i] = even ? 0 : 2 + $urandom % (rv[i] - 2);
      ratio[i] <= 32'(rv[i]);
      width[i] <= 32'(wv[i]);
      dm[i] <= 1'($urandom % 2);
      ci[i] <= 1'($urandom % 2);
    end
    for (int i = 0; i < N; i++) begin
      wait_per(i);
      wait_per(i);
      check_per(i, rv[i], wv[i], 0);
    end
    mon_en = 1'b1;
  endtask

  // request right after a rise so the boundary that takes it is the end of the current period
  task automatic step_test(input int i, input int s);
    wait_per(i);
    @(posedge clk_sys);
    step[i] <= ADJ_W'(s);
    req[i] <= 1'b1;
    @(posedge clk_sys);
    req[i] <= 1'b0;
    #1;
    chk_bit(pend[i], 1'b1);
    check_per(i, rv[i], wv[i], 0);
    chk_bit(pend[i], 1'b0);
    check_per(i, rv[i], wv[i], s);
    check_per(i, rv[i], wv[i], 0);
  endtask

  // pin relation is checked on the falling edge, away from the registered updates
  always @(negedge clk_sys) begin
    if (mon_en) begin
      for (int i = 0; i < N; i++) begin
        chk_bit(cp[i], (dm[i] | ci[i]) ? ~tp[i] : tp[i]);
      end
    end
  end

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    #900000;
    num_errors++;
    stop_test();
  end

  initial begin
    void'($urandom(80285));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int n = 0; n < 4; n++) begin
      setup(n % 2 == 0);
      for (int i = 0; i < N; i++) begin
        step_test(i, int'($urandom % 24) - 3);
        step_test(i, -1000);
      end
    end
    @(posedge clk_sys);
    sel4 <= 1'b1;
    sel7 <= 1'b1;
    for (int i = 0; i < N; i++) begin
      wait_per(i);
      wait_per(i);
      check_per(i, rv[i], wv[i], 0);
    end
    chk_bit(siu[0], 1'b1);
    chk_bit(siu[3], 1'b1);
    chk_bit(siu[1], 1'b0);
    chk_bit(siu[2], 1'b0);
    // a low enable freezes the pins and ignores a step request
    @(posedge clk_sys);
    en <= 1'b0;
    @(posedge clk_sys);
    req[0] <= 1'b1;
    #1;
    frz = tp;
    @(posedge clk_sys);
    req[0] <= 1'b0;
    repeat (20) @(posedge clk_sys);
    #1;
    chk_bit(pend[0], 1'b0);
    for (int i = 0; i < N; i++) begin
      chk_bit(tp[i], frz[i]);
    end
    @(posedge clk_sys);
    en <= 1'b1;
    stop_test();
  end
endmodule
